/* File: design/ppp_pkg.sv */
// package for the parallel nvm programming port: command codes, select
// encodings, timing constants. assumes a 25 MHz core clock.
package ppp_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam logic [1:0] ACT_ADDR       = 2'h0;
  localparam logic [1:0] ACT_DATA       = 2'h1;
  localparam logic [1:0] ACT_CMD        = 2'h2;
  localparam logic [1:0] ACT_IDLE       = 2'h3;
  localparam logic [1:0] BSEL_LO        = 2'h0;
  localparam logic [1:0] BSEL_HI        = 2'h1;
  localparam logic [1:0] BSEL_EXT       = 2'h2;
  localparam logic [1:0] BSEL_FHI       = 2'h3;
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_ERASE      = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EE      = 8'h11;
  localparam logic [7:0] CMD_RD_ID      = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
  localparam logic [7:0] CMD_RD_EE      = 8'h03;
  localparam logic [7:0] ERASED_BYTE    = 8'hff;
  localparam logic [7:0] ID_MAX_ADDR    = 8'h02;
  // write busy window 3.7..4.5 ms, erase 7.5..9 ms, in microseconds
  localparam int unsigned WR_MIN_US     = 3700;
  localparam int unsigned WR_MAX_US     = 4500;
  localparam int unsigned CE_MIN_US     = 7500;
  localparam int unsigned CE_MAX_US     = 9000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1000000;
  // target the middle of each window
  localparam int unsigned WR_BUSY_CYC   =
    (WR_MIN_US + WR_MAX_US) / 2 * CYC_PER_US;
  localparam int unsigned CE_BUSY_CYC   =
    (CE_MIN_US + CE_MAX_US) / 2 * CYC_PER_US;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned FIFO_WIDTH    = 24;
endpackage

/* File: design/ppp_fifo.sv */
// synchronous fifo with valid/ready on both sides.
// assumes one clock, async active-low reset, clock enable freezes all.
`timescale 1ns/10ps
module ppp_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk_in, // core clock
  input  wire logic             rstn_in,     // async reset, active low
  input  wire logic             ce_in,       // clock enable
  input  wire logic             in_valid_in, // write request
  output logic                  in_ready_out,// not full
  input  wire logic [WIDTH-1:0] in_data_in,  // write data
  output logic                  out_valid_out,// not empty
  input  wire logic             out_ready_in,// read accept
  output logic [WIDTH-1:0]      out_data_out // head word
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;
  wire [AW:0]       depth_w = (AW+1)'(DEPTH);

  assign in_ready_out  = cnt_r != depth_w;
  assign out_valid_out = cnt_r != '0;
  assign out_data_out  = mem_r[rp_r];

  always_ff @(posedge core_clk_in) begin
    if (ce_in && push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce_in) begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

/* File: design/ppp_port.sv */
// parallel programming port of the on-chip nonvolatile memories.
// assumes the programmer's pins are synchronous to core_clk_in and that
// pulses last at least one clock; load and latch act at their rising edge, the write pulse at its falling edge.
// Operation
// [RULE_01] page latch with byte select one high stores data word at address
// [RULE_02] programmer repeats address, data and latch for every word
// [RULE_03] low address bits pick word in page, upper bits pick page
// [RULE_04] address load with byte select 01 captures address bits 15..8
// [RULE_05] address load with byte select 10 captures address bits 23..16
// [RULE_06] write pulse with select 00 programs flash page, busy low
// [RULE_07] programmer repeats page sequence until all flash is written
// [RULE_08] nop command ends page programming and clears write state
// [RULE_09] eeprom write loads bytes, latches, then write pulse programs page
// [RULE_10] flash read drives low byte, byte select one high gives high
// [RULE_11] eeprom read drives addressed byte with byte select one low
// [RULE_12] fuse write: low byte at select 00, zero bit means programmed
// [RULE_13] fuse write with select 01 targets the high fuse byte
// [RULE_14] fuse write with select 10 targets the extended fuse byte
// [RULE_15] lock write programs zero bits; mode 3 blocks boot lock bits
// [RULE_16] lock bits return to erased only by chip erase; reset also reloads lock_r to 0xff here
// [RULE_17] fuse read: 00 low, 11 high, 10 extended, 01 lock bits
// [RULE_18] id read outputs id byte for address 0x00 to 0x02
// [RULE_19] id read at address 0x00 with byte select one high gives calib
// [RULE_20] writes keep ready/busy low 3.7 to 4.5 ms, low within 1 us
// [RULE_21] chip erase keeps ready/busy low 7.5 to 9 ms
// [RULE_22] action select: 00 address, 01 data, 10 command, 11 idle
// [RULE_23] ready/busy is low while programming, high when ready
// [RULE_24] data bus is driven only while output enable is low; here the bus enable follows oe_n_in one clock late
// [RULE_25] activity while busy is ignored until the operation ends
`timescale 1ns/10ps
module ppp_port
  import ppp_pkg::*;
#(
  parameter int unsigned PAGE_BITS = 7,    // log2 of words per flash page
  parameter int unsigned FL_ABITS  = 15,   // flash word address bits
  parameter int unsigned EE_ABITS  = 11,   // eeprom byte address bits
  parameter int unsigned EE_PBITS  = 3,    // log2 of bytes per eeprom page
  parameter int unsigned WR_CYC    = ppp_pkg::WR_BUSY_CYC,
  parameter int unsigned CE_CYC    = ppp_pkg::CE_BUSY_CYC,
  parameter logic [7:0]  ID0       = 8'h5a,  // arbitrary id value
  parameter logic [7:0]  ID1       = 8'h3c,  // arbitrary id value
  parameter logic [7:0]  ID2       = 8'h01,  // arbitrary id value
  parameter logic [7:0]  CALIB     = 8'h80   // calibration default
) (
  input  wire logic       core_clk_in,          // core clock 25 MHz
  input  wire logic       rstn_in,              // async reset, active low
  input  wire logic       ce_in,                // clock enable, freeze low
  input  wire logic       load_strobe_in,       // strobe, rising acts
  input  wire logic       action_select_hi_in,  // action select bit 1
  input  wire logic       action_select_lo_in,  // action select bit 0
  input  wire logic       byte_select_one_in,   // byte select one
  input  wire logic       byte_select_two_in,   // byte select two
  input  wire logic       page_latch_pulse_in,  // page latch, rising acts
  input  wire logic       write_n_in,           // write pulse, active low
  input  wire logic       oe_n_in,              // output enable, active low
  input  wire logic [7:0] data_in,              // data bus input side
  output logic      [7:0] data_out,             // data bus output side
  output logic            data_oe_n_out,        // bus enable, low drives
  output logic            ready_busy_out        // 1 ready, 0 busy
);
  localparam int unsigned FL_WORDS = 1 << FL_ABITS;
  localparam int unsigned EE_BYTES = 1 << EE_ABITS;
  localparam int unsigned FL_PW    = 1 << PAGE_BITS;
  localparam int unsigned EE_PW    = 1 << EE_PBITS;
  localparam int unsigned CW       = $clog2(CE_CYC + 1);

  logic [15:0] flash_mem [FL_WORDS];
  logic [7:0]  ee_mem    [EE_BYTES];
  logic [15:0] fl_buf    [FL_PW];
  logic [7:0]  ee_buf    [EE_PW];
  logic [FL_PW-1:0] fl_vld_r;
  logic [EE_PW-1:0] ee_vld_r;

  logic [7:0]  cmd_r;
  logic [23:0] addr_r;
  logic [7:0]  dlo_r;
  logic [7:0]  dhi_r;
  logic [7:0]  fuse_lo_r;
  logic [7:0]  fuse_hi_r;
  logic [7:0]  fuse_ext_r;
  logic [7:0]  lock_r;
  logic        strobe_d_r;
  logic        latch_d_r;
  logic        write_d_r;
  logic [CW-1:0] busy_cnt_r;
  logic [7:0]  rd_r;
  logic        oe_n_r;

  // edges of the programmer's strobes: rising for load and latch, falling for write
  wire [1:0] act     = {action_select_hi_in, action_select_lo_in};
  wire [1:0] bsel    = {byte_select_two_in, byte_select_one_in};
  wire       busy    = busy_cnt_r != '0;
  wire       strobe  = load_strobe_in && !strobe_d_r && !busy; // RULE_25
  wire       latch   = page_latch_pulse_in && !latch_d_r && !busy;
  wire       wr_fall = !write_n_in && write_d_r && !busy;

  wire       ld_addr = strobe && act == ACT_ADDR;             // RULE_22
  wire       ld_data = strobe && act == ACT_DATA;             // RULE_22
  wire       ld_cmd  = strobe && act == ACT_CMD;              // RULE_22

  wire [PAGE_BITS-1:0] fl_word = addr_r[PAGE_BITS-1:0];       // RULE_03
  wire [FL_ABITS-1:PAGE_BITS] fl_page =
    addr_r[FL_ABITS-1:PAGE_BITS];                             // RULE_03
  wire [EE_PBITS-1:0] ee_word = addr_r[EE_PBITS-1:0];
  wire [EE_ABITS-1:EE_PBITS] ee_page = addr_r[EE_ABITS-1:EE_PBITS];
  wire [FL_ABITS-1:0] fl_addr = addr_r[FL_ABITS-1:0];
  wire [EE_ABITS-1:0] ee_addr = addr_r[EE_ABITS-1:0];

  wire is_fl_wr = cmd_r == CMD_WR_FLASH;
  wire is_ee_wr = cmd_r == CMD_WR_EE;
  wire do_page  = wr_fall && bsel == BSEL_LO;                 // RULE_06
  // lock mode 3: both protection bits programmed (zero)
  wire lock_m3  = lock_r[1:0] == 2'b00;                       // RULE_15
  // boot lock bits 5..2 may not be programmed further in mode 3
  wire [7:0] lock_wr = lock_m3 ?
    (lock_r & {2'b11, lock_r[5:2], dlo_r[1:0]}) :
    (lock_r & dlo_r);                                         // RULE_16

  // finished eeprom pages leave through the fifo so long writes can queue up; flash pages go straight to the array
  logic        q_valid;
  logic        q_ready;
  logic [23:0] q_data;
  logic        d_valid;
  logic [23:0] d_data;
  logic        f_ready;
  logic [FL_ABITS-1:0] q_slot;
  // word index walked while draining the buffer into the array
  logic [PAGE_BITS-1:0] drain_r;
  logic        draining_r;
  logic        drain_ee_r;
  logic [FL_ABITS-1:PAGE_BITS] drain_pg_r;
  logic [EE_ABITS-1:EE_PBITS]  drain_epg_r;

  assign q_valid = draining_r &&
    (drain_ee_r ? ee_vld_r[drain_r[EE_PBITS-1:0]] : fl_vld_r[drain_r]);
  assign q_data  = drain_ee_r ?
    // the whole eeprom byte address rides in bits 22..8, so no page is lost
    {1'b1, 15'({drain_epg_r, drain_r[EE_PBITS-1:0]}),
     ee_buf[drain_r[EE_PBITS-1:0]]} :
    {1'b0, 7'(FL_ABITS'({drain_pg_r, drain_r}) >> 8), 8'h00,
     8'h00};
  assign q_slot  = {drain_pg_r, drain_r};
  assign q_ready = 1'b1;

  ppp_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .rstn_in      (rstn_in),
    .ce_in        (ce_in),
    .in_valid_in  (q_valid && drain_ee_r),
    .in_ready_out (f_ready),
    .in_data_in   (q_data),
    .out_valid_out(d_valid),
    .out_ready_in (q_ready),
    .out_data_out (d_data)
  );

  // on eeprom pages the drain walker advances only when the fifo accepts, so a full fifo
  // stalls the eeprom page commit; on flash pages it advances every cycle
  wire step = draining_r && (!drain_ee_r || f_ready);
  wire last = drain_ee_r ? (drain_r == PAGE_BITS'(EE_PW - 1)) :
                           (drain_r == PAGE_BITS'(FL_PW - 1));

  always_ff @(posedge core_clk_in) begin
    if (ce_in) begin
      if (latch && byte_select_one_in && is_fl_wr)
        fl_buf[fl_word] <= {dhi_r, dlo_r};                    // RULE_01
      if (latch && is_ee_wr)
        ee_buf[ee_word] <= dlo_r;                             // RULE_09
      if (step && !drain_ee_r && fl_vld_r[drain_r])
        flash_mem[q_slot] <= fl_buf[drain_r];                 // RULE_06
      if (d_valid)
        ee_mem[d_data[8+EE_ABITS-1:8]] <= d_data[7:0];        // RULE_09
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_r       <= CMD_NOP;
      addr_r      <= '0;
      dlo_r       <= ERASED_BYTE;
      dhi_r       <= ERASED_BYTE;
      fuse_lo_r   <= ERASED_BYTE;
      fuse_hi_r   <= ERASED_BYTE;
      fuse_ext_r  <= ERASED_BYTE;
      lock_r      <= ERASED_BYTE;
      strobe_d_r  <= 1'b0;
      latch_d_r   <= 1'b0;
      write_d_r   <= 1'b1;
      busy_cnt_r  <= '0;
      fl_vld_r    <= '0;
      ee_vld_r    <= '0;
      draining_r  <= 1'b0;
      drain_ee_r  <= 1'b0;
      drain_r     <= '0;
      drain_pg_r  <= '0;
      drain_epg_r <= '0;
    end else if (ce_in) begin
      strobe_d_r <= load_strobe_in;
      latch_d_r  <= page_latch_pulse_in;
      write_d_r  <= write_n_in;
      if (ld_cmd) begin
        cmd_r <= data_in;
        if (data_in == CMD_NOP) begin
          fl_vld_r <= '0;                                     // RULE_08
          ee_vld_r <= '0;                                     // RULE_08
        end
      end
      if (ld_addr) begin
        unique case (bsel)
          BSEL_LO:  addr_r[7:0]   <= data_in;
          BSEL_HI:  addr_r[15:8]  <= data_in;                 // RULE_04
          BSEL_EXT: addr_r[23:16] <= data_in;                 // RULE_05
          BSEL_FHI: addr_r        <= addr_r;
        endcase
      end
      if (ld_data) begin
        if (byte_select_one_in) dhi_r <= data_in;
        else                    dlo_r <= data_in;
      end
      if (latch && byte_select_one_in && is_fl_wr)
        fl_vld_r[fl_word] <= 1'b1;                            // RULE_01
      if (latch && is_ee_wr)
        ee_vld_r[ee_word] <= 1'b1;
      if (busy_cnt_r != '0)
        busy_cnt_r <= busy_cnt_r - 1'b1;                      // RULE_20
      if (wr_fall) begin
        busy_cnt_r <= (cmd_r == CMD_ERASE) ? CW'(CE_CYC) :
                                             CW'(WR_CYC);     // RULE_21
        if (cmd_r == CMD_WR_FUSE) begin
          unique case (bsel)
            BSEL_LO:  fuse_lo_r  <= dlo_r;                    // RULE_12
            BSEL_HI:  fuse_hi_r  <= dlo_r;                    // RULE_13
            BSEL_EXT: fuse_ext_r <= dlo_r;                    // RULE_14
            BSEL_FHI: fuse_lo_r  <= fuse_lo_r;
          endcase
        end
        if (cmd_r == CMD_WR_LOCK)
          lock_r <= lock_wr;                                  // RULE_15
        if (cmd_r == CMD_ERASE)
          lock_r <= ERASED_BYTE;                              // RULE_16
        if (do_page && (is_fl_wr || is_ee_wr)) begin
          draining_r  <= 1'b1;
          drain_ee_r  <= is_ee_wr;
          drain_r     <= '0;
          drain_pg_r  <= fl_page;
          drain_epg_r <= ee_page;
        end
      end
      if (step) begin
        if (drain_ee_r) ee_vld_r[drain_r[EE_PBITS-1:0]] <= 1'b0;
        else            fl_vld_r[drain_r] <= 1'b0;
        drain_r <= drain_r + 1'b1;
        if (last) draining_r <= 1'b0;
      end
    end
  end

  // read data mux, chosen from command and selects
  logic [7:0] rd_nxt;
  always_comb begin
    rd_nxt = ERASED_BYTE;
    unique case (cmd_r)
      CMD_RD_FLASH: rd_nxt = byte_select_one_in ?
        flash_mem[fl_addr][15:8] : flash_mem[fl_addr][7:0];   // RULE_10
      CMD_RD_EE:    rd_nxt = ee_mem[ee_addr];                 // RULE_11
      CMD_RD_FUSE: begin
        unique case (bsel)
          BSEL_LO:  rd_nxt = fuse_lo_r;                       // RULE_17
          BSEL_FHI: rd_nxt = fuse_hi_r;
          BSEL_EXT: rd_nxt = fuse_ext_r;
          BSEL_HI:  rd_nxt = lock_r;
        endcase
      end
      CMD_RD_ID: begin
        if (byte_select_one_in)
          rd_nxt = (addr_r[7:0] == 8'h00) ? CALIB : ERASED_BYTE; // RULE_19
        else if (addr_r[7:0] == 8'h00) rd_nxt = ID0;          // RULE_18
        else if (addr_r[7:0] == 8'h01) rd_nxt = ID1;
        else if (addr_r[7:0] == ID_MAX_ADDR) rd_nxt = ID2;
      end
      default: rd_nxt = ERASED_BYTE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_r   <= '0;
      oe_n_r <= 1'b1;
    end else if (ce_in) begin
      rd_r   <= rd_nxt;
      oe_n_r <= oe_n_in;                                      // RULE_24
    end
  end

  assign data_out       = rd_r;
  assign data_oe_n_out  = oe_n_r;                             // RULE_24
  assign ready_busy_out = !busy;                              // RULE_23

  // assertions
  sequence s_write_fall;
    wr_fall && cmd_r != CMD_ERASE;
  endsequence
  property p_busy_prompt;
    @(posedge core_clk_in) disable iff (!rstn_in)
    s_write_fall ##1 ce_in |-> !ready_busy_out;
  endproperty
  a_busy_prompt: assert property (p_busy_prompt)  // RULE_20
    else $error("ready/busy not low after write");
  property p_busy_load;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && wr_fall |=> busy_cnt_r == ((cmd_r == CMD_ERASE) ?
      CW'(CE_CYC) : CW'(WR_CYC)) || !ce_in;
  endproperty
  a_busy_load: assert property (p_busy_load)  // RULE_21
    else $error("busy count wrong after write pulse");
  property p_oe;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ce_in |=> data_oe_n_out == $past(oe_n_in);
  endproperty
  a_oe: assert property (p_oe)  // RULE_24
    else $error("bus enable does not follow output enable");
  property p_rdy;
    @(posedge core_clk_in) disable iff (!rstn_in)
    $fell(ready_busy_out) |-> $past(wr_fall);
  endproperty
  a_rdy: assert property (p_rdy)  // RULE_23
    else $error("ready/busy fell without a write pulse");
  property p_addr_hi;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && ld_addr && bsel == BSEL_HI |=>
      addr_r[15:8] == $past(data_in) || !ce_in;
  endproperty
  a_addr_hi: assert property (p_addr_hi)  // RULE_04
    else $error("address high byte not captured");
  property p_addr_ext;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && ld_addr && bsel == BSEL_EXT |=>
      addr_r[23:16] == $past(data_in) || !ce_in;
  endproperty
  a_addr_ext: assert property (p_addr_ext)  // RULE_05
    else $error("extended address byte not captured");
  property p_nop;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && ld_cmd && data_in == CMD_NOP && !draining_r && !latch |=>
      fl_vld_r == '0 || !ce_in;
  endproperty
  a_nop: assert property (p_nop)  // RULE_08
    else $error("nop did not clear page buffer state");
  property p_lock_sticky;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && !(wr_fall && cmd_r == CMD_ERASE) |=>
      (lock_r & ~$past(lock_r)) == 8'h00;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)  // RULE_16
    else $error("lock bit erased without chip erase");
  property p_idle_act;
    @(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && strobe && act == ACT_IDLE |=>
      cmd_r == $past(cmd_r) && addr_r == $past(addr_r);
  endproperty
  a_idle_act: assert property (p_idle_act)  // RULE_22
    else $error("idle action changed state");
endmodule

/* File: verif/ppp_prog_model.sv */
// behavioural parallel programmer driving the port's pins.
// assumes the bench calls its tasks and resolves the data bus.
`timescale 1ns/10ps
module ppp_prog_model (
  input  wire logic        clk_in,   // core clock
  input  wire logic        rdy_in,   // ready/busy from device
  input  wire logic        doe_n_in, // device bus enable, low drives
  input  wire logic [7:0]  bus_in,   // resolved data bus
  output logic             strb_out, // load strobe
  output logic             ahi_out,  // action select bit 1
  output logic             alo_out,  // action select bit 0
  output logic             bs1_out,  // byte select one
  output logic             bs2_out,  // byte select two
  output logic             pl_out,   // page latch pulse
  output logic             wn_out,   // write pulse, active low
  output logic             oen_out,  // output enable, active low
  output logic [7:0]       dq_out,   // data driven while oen_out high
  output logic             rv_out,   // result valid
  output logic [15:0]      rd_out    // result value
);
  initial begin
    {strb_out, ahi_out, alo_out, bs1_out, bs2_out} = 5'b01100;
    {pl_out, wn_out, oen_out, rv_out} = 4'b0110;
    dq_out = 8'h00;
    rd_out = 16'h0000;
  end
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic emit(input logic [15:0] v);
    rd_out = v;
    rv_out = 1'b1;
    tick();
    rv_out = 1'b0;
  endtask
  // a stuck busy shows up as a bogus result rather than a silent hang
  task automatic idle();
    int n;
    for (n = 0; n < 1000 && rdy_in !== 1'b1; n++) tick();
    if (n == 1000) emit(16'hbad0);
  endtask
  task automatic ld(input logic [1:0] a, b, input logic [7:0] d);
    idle();
    {ahi_out, alo_out, bs2_out, bs1_out} = {a, b};
    dq_out = d;
    tick();
    strb_out = 1'b1;
    tick();
    strb_out = 1'b0;
    tick();
  endtask
  task automatic latch();
    bs1_out = 1'b1;
    tick();
    pl_out = 1'b1;
    tick();
    pl_out = 1'b0;
    tick();
  endtask
  // result 1 when busy fell within 25 cycles and lasted cyc +-2 cycles
  task automatic wr(input logic [1:0] b, input int cyc);
    int lo;
    int n;
    {bs2_out, bs1_out} = b;
    tick();
    wn_out = 1'b0;
    tick();
    wn_out = 1'b1;
    for (lo = 1; lo < 30 && rdy_in; lo++) tick();
    for (n = 0; n < 2 * cyc && !rdy_in; n++) tick();
    emit((lo < 26 && n >= cyc - 2 && n <= cyc + 2) ? 16'h1 : 16'(n));
    {bs2_out, bs1_out} = 2'b00;
  endtask
  task automatic rd(input logic [1:0] b);
    {bs2_out, bs1_out} = b;
    oen_out = 1'b0;
    tick();
    tick();
    emit({7'h0, doe_n_in, bus_in});
    oen_out = 1'b1;
    tick();
    tick();
    emit({7'h0, doe_n_in, 8'h00});
  endtask
endmodule

/* File: verif/parallel_nvm_programming_port_test.sv */
// self-checking bench for ppp_port with a programmer model.
// assumes shortened busy counts; results are matched against a queue.
`timescale 1ns/10ps
module parallel_nvm_programming_port_test;
  import ppp_pkg::*;
  localparam int WC = 200;
  localparam int CC = 400;
  localparam logic [7:0] I0 = 8'h5a; // arbitrary id value
  localparam logic [7:0] I1 = 8'h3c; // arbitrary id value
  localparam logic [7:0] I2 = 8'h01; // arbitrary id value
  localparam logic [7:0] CAL = 8'h80;
  logic clk, rstn, strb, ahi, alo, bs1, bs2, pl, wn, oen, rv, doe_n, rdy, ce;
  logic [7:0] dq, dout, bus;
  logic [15:0] rdat;
  logic [15:0] expq[$];
  int n_errors;
  int compares;
  // released bus shows the inverse of the last driven value
  assign bus = !doe_n ? dout : (oen ? dq : ~dq);
  ppp_port #(.WR_CYC(WC), .CE_CYC(CC), .ID0(I0), .ID1(I1), .ID2(I2),
    .CALIB(CAL)) dut_u (
    .core_clk_in(clk), .rstn_in(rstn), .ce_in(ce),
    .load_strobe_in(strb), .action_select_hi_in(ahi),
    .action_select_lo_in(alo), .byte_select_one_in(bs1),
    .byte_select_two_in(bs2), .page_latch_pulse_in(pl),
    .write_n_in(wn), .oe_n_in(oen), .data_in(bus), .data_out(dout),
    .data_oe_n_out(doe_n), .ready_busy_out(rdy));
  ppp_prog_model pg (
    .clk_in(clk), .rdy_in(rdy), .doe_n_in(doe_n), .bus_in(bus),
    .strb_out(strb), .ahi_out(ahi), .alo_out(alo), .bs1_out(bs1),
    .bs2_out(bs2), .pl_out(pl), .wn_out(wn), .oen_out(oen),
    .dq_out(dq), .rv_out(rv), .rd_out(rdat));
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic close_out();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wrx(input logic [1:0] b, input int cyc);
    expq.push_back(16'h1);
    pg.wr(b, cyc);
  endtask
  task automatic rdx(input logic [1:0] b, input logic [7:0] e);
    expq.push_back({8'h00, e});
    expq.push_back(16'h0100);
    pg.rd(b);
  endtask
  function automatic logic [7:0] fa(input int i);
    return {i[1], 7'(5 + i[0])};
  endfunction
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      if (expq.size() == 0) chk(16'hdead, rdat);
      else chk(expq.pop_front(), rdat);
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    logic [15:0] fw[4];
    logic [7:0] eb[8];
    logic [7:0] fz[3];
    int i;
    rstn = 1'b0;
    ce = 1'b1;
    n_errors = 0;
    compares = 0;
    void'($urandom(32'h0ff0));
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    chk(16'h1, {15'h0, rdy});
    pg.ld(ACT_CMD, BSEL_LO, CMD_WR_FLASH);
    pg.ld(ACT_ADDR, BSEL_EXT, 8'h01);
    pg.ld(ACT_ADDR, BSEL_HI, 8'h12);
    for (i = 0; i < 4; i++) begin
      fw[i] = 16'($urandom);
      pg.ld(ACT_ADDR, BSEL_LO, fa(i));
      pg.ld(ACT_DATA, BSEL_LO, fw[i][7:0]);
      pg.ld(ACT_DATA, BSEL_HI, fw[i][15:8]);
      pg.latch();
      if (i[0]) wrx(BSEL_LO, WC);
    end
    pg.ld(ACT_CMD, BSEL_LO, CMD_NOP);
    pg.ld(ACT_CMD, BSEL_LO, CMD_RD_FLASH);
    for (i = 0; i < 4; i++) begin
      pg.ld(ACT_ADDR, BSEL_LO, fa(i));
      rdx(BSEL_LO, fw[i][7:0]);
      rdx(BSEL_HI, fw[i][15:8]);
    end
    $display("flash test done");
    pg.ld(ACT_CMD, BSEL_LO, CMD_WR_EE);
    pg.ld(ACT_ADDR, BSEL_HI, 8'h01);
    for (i = 0; i < 8; i++) begin
      eb[i] = 8'($urandom);
      pg.ld(ACT_ADDR, BSEL_LO, 8'(8 + i));
      pg.ld(ACT_DATA, BSEL_LO, eb[i]);
      pg.latch();
    end
    wrx(BSEL_LO, WC);
    pg.ld(ACT_CMD, BSEL_LO, CMD_RD_EE);
    for (i = 0; i < 8; i++) begin
      pg.ld(ACT_ADDR, BSEL_LO, 8'(8 + i));
      rdx(BSEL_LO, eb[i]);
    end
    $display("eeprom test done");
    pg.ld(ACT_CMD, BSEL_LO, CMD_WR_FUSE);
    for (i = 0; i < 3; i++) begin
      fz[i] = 8'($urandom);
      pg.ld(ACT_DATA, BSEL_LO, fz[i]);
      wrx(2'(i), WC);
    end
    pg.ld(ACT_CMD, BSEL_LO, CMD_RD_FUSE);
    rdx(BSEL_LO, fz[0]);
    rdx(BSEL_FHI, fz[1]);
    rdx(BSEL_EXT, fz[2]);
    $display("fuse test done");
    // mode 3 first, then try boot bits, then try to erase by writing ones
    pg.ld(ACT_CMD, BSEL_LO, CMD_WR_LOCK);
    for (i = 0; i < 3; i++) begin
      pg.ld(ACT_DATA, BSEL_LO, i == 0 ? 8'hfc : (i == 1 ? 8'hc3 : 8'hff));
      wrx(BSEL_LO, WC);
    end
    pg.ld(ACT_CMD, BSEL_LO, CMD_RD_FUSE);
    rdx(BSEL_HI, 8'hfc);
    pg.ld(ACT_CMD, BSEL_LO, CMD_ERASE);
    // enable drops for 20 edges mid-erase, so busy must stretch by as much
    fork
      wrx(BSEL_LO, CC + 20);
      begin
        repeat (50) @(posedge clk);
        #1 ce = 1'b0;
        repeat (20) @(posedge clk);
        #1 ce = 1'b1;
      end
    join
    pg.ld(ACT_CMD, BSEL_LO, CMD_RD_FUSE);
    rdx(BSEL_HI, 8'hff);
    rdx(BSEL_LO, fz[0]);
    $display("lock test done");
    pg.ld(ACT_CMD, BSEL_LO, CMD_RD_ID);
    pg.ld(ACT_IDLE, BSEL_LO, CMD_NOP);
    for (i = 0; i < 3; i++) begin
      pg.ld(ACT_ADDR, BSEL_LO, 8'(i));
      rdx(BSEL_LO, i == 0 ? I0 : (i == 1 ? I1 : I2));
    end
    pg.ld(ACT_ADDR, BSEL_LO, 8'h00);
    rdx(BSEL_HI, CAL);
    $display("id test done");
    repeat (4) @(posedge clk);
    if (expq.size() != 0) n_errors++;
    close_out();
  end
endmodule
